// [design/asf_status_flags.sv]
/*
 * ALU status flag block of an 8-bit core. Computes result and flags for
 * the issued operation and keeps the flag register, which is also
 * reachable through a plain register port and as an instruction target.
 * Assumes the core presents one operation per cycle on op_valid and that
 * the register port and core never write the register in the same cycle.
 */
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
module asf_status_flags (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic op_valid,
   input wire asf_pkg::asf_op_t op_code,
   input wire logic [7:0] op_a,
   input wire logic [7:0] op_b,
   input wire logic [2:0] op_bit,
   input wire logic op_src_flags,
   input wire logic op_dst_flags,
   output logic [7:0] op_result,
   output logic op_done,
   input wire logic indexed_mode_req,
   output logic indexed_mode_ok
);
   // Stored flags N, OV, Z, DC, C
   logic [4:0] flags_reg;
   logic [4:0] flags_next;
   // Configuration bits; bit 0 enables the extended set
   logic [7:0] cfg_reg;
   // Result register
   logic [7:0] result_reg;
   logic [7:0] result_next;
   // Operand A, replaced by the flag register when it is the source
   logic [7:0] src_a;
   // Adder hookup
   logic [7:0] add_b;
   logic add_cin;
   logic [7:0] add_sum;
   logic add_dc;
   logic add_c;
   logic add_ov;
   // Rotator hookup
   logic [7:0] rot_res;
   logic rot_c;
   logic rot_dc;
   logic is_sub;
   logic is_left;
   logic done_reg;

   // Read view of the flags with unimplemented bits at zero
   function automatic logic [7:0] flags_view(input logic [4:0] f);
      flags_view = {3'h0, f} & asf_pkg::ASF_IMPL_MASK;
   endfunction

   // Source selection: flag register reads like any register
   always_comb begin
      src_a = op_src_flags ? flags_view(flags_reg) : op_a;
   end

   // Subtract adds the two's complement of the second operand
   always_comb begin
      is_sub = (op_code == asf_pkg::ASF_OP_SUB);
      is_left = (op_code == asf_pkg::ASF_OP_RLC);
      add_b = is_sub ? ~op_b : op_b;
      add_cin = is_sub;
   end

   asf_adder u_adder (
      .a(src_a),
      .b(add_b),
      .cin(add_cin),
      .sum(add_sum),
      .nib_carry(add_dc),
      .carry(add_c),
      .ovf(add_ov)
   );

   asf_rotator u_rot (
      .src(src_a),
      .cin(flags_reg[asf_pkg::ASF_C_POS]),
      .left(is_left),
      .res(rot_res),
      .cout(rot_c),
      .dcout(rot_dc)
   );

   // Result and flag computation per operation
   always_comb begin
      result_next = result_reg;
      flags_next = flags_reg;
      if (op_valid) begin
         case (op_code)
            asf_pkg::ASF_OP_ADD, asf_pkg::ASF_OP_SUB: begin
               result_next = add_sum;
               flags_next[asf_pkg::ASF_N_POS] = add_sum[7];
               flags_next[asf_pkg::ASF_OV_POS] = add_ov;
               flags_next[asf_pkg::ASF_Z_POS] = (add_sum == 8'h00);
               flags_next[asf_pkg::ASF_DC_POS] = add_dc;
               flags_next[asf_pkg::ASF_C_POS] = add_c;
            end
            asf_pkg::ASF_OP_RRC, asf_pkg::ASF_OP_RLC: begin
               result_next = rot_res;
               flags_next[asf_pkg::ASF_DC_POS] = rot_dc;
               flags_next[asf_pkg::ASF_C_POS] = rot_c;
            end
            asf_pkg::ASF_OP_LOGIC: begin
               // Logic result arrives on op_b; only N and Z move
               result_next = op_b;
               flags_next[asf_pkg::ASF_N_POS] = op_b[7];
               flags_next[asf_pkg::ASF_Z_POS] = (op_b == 8'h00);
            end
            asf_pkg::ASF_OP_CLR: begin
               result_next = 8'h00;
               flags_next[asf_pkg::ASF_Z_POS] = 1'b1;
            end
            asf_pkg::ASF_OP_BCLR: begin
               result_next = src_a & ~(8'h01 << op_bit);
            end
            asf_pkg::ASF_OP_BSET: begin
               result_next = src_a | (8'h01 << op_bit);
            end
            asf_pkg::ASF_OP_SWAP: begin
               result_next = {src_a[3:0], src_a[7:4]};
            end
            asf_pkg::ASF_OP_MOVE: begin
               result_next = src_a;
            end
            default: begin
               result_next = result_reg;
            end
         endcase
         // Writes into the flag register by non-affecting ops land directly
         if (op_dst_flags) begin
            case (op_code)
               asf_pkg::ASF_OP_BCLR, asf_pkg::ASF_OP_BSET,
               asf_pkg::ASF_OP_SWAP, asf_pkg::ASF_OP_MOVE: begin
                  flags_next = result_next[4:0];
               end
               default: begin
                  // Affecting ops and ASF_OP_NONE: written value blocked, flag logic stands
               end
            endcase
         end
      end else if (reg_wr && reg_addr == asf_pkg::ASF_FLAGS_ADDR) begin
         flags_next = reg_wdata[4:0];
      end
   end

   // Flag register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         flags_reg <= asf_pkg::ASF_FLAGS_RESET;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // Result register and completion strobe
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         result_reg <= 8'h00;
         done_reg <= 1'b0;
      end else begin
         result_reg <= result_next;
         done_reg <= op_valid && (op_code != asf_pkg::ASF_OP_NONE);
      end
   end

   // Configuration register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cfg_reg <= asf_pkg::ASF_CFG_RESET;
      end else if (reg_wr && reg_addr == asf_pkg::ASF_CFG_ADDR) begin
         cfg_reg <= {7'h00, reg_wdata[asf_pkg::ASF_XSET_POS]};
      end
   end

   // Register port read data, one cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            asf_pkg::ASF_FLAGS_ADDR: reg_rdata <= flags_view(flags_reg);
            asf_pkg::ASF_CFG_ADDR: reg_rdata <= cfg_reg;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Outputs
   always_comb begin
      op_result = result_reg;
      op_done = done_reg;
      indexed_mode_ok = indexed_mode_req && cfg_reg[asf_pkg::ASF_XSET_POS];
   end

   // Checks
   chk_upper_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
      reg_rd |=> reg_rdata[7:5] == 3'h0) else $error("upper bits nonzero");
   chk_clr_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
      op_valid && op_code == asf_pkg::ASF_OP_CLR |=>
      flags_reg[2] && flags_reg[1:0] == $past(flags_reg[1:0]) &&
      flags_reg[4:3] == $past(flags_reg[4:3])) else $error("clear flags wrong");
   chk_neg_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
      op_valid && op_code == asf_pkg::ASF_OP_ADD |=>
      flags_reg[4] == op_result[7]) else $error("negative wrong");
   chk_zero_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
      op_valid && (op_code == asf_pkg::ASF_OP_ADD || op_code == asf_pkg::ASF_OP_SUB) |=>
      flags_reg[2] == (op_result == 8'h00)) else $error("zero wrong");
   chk_ovf_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
      op_valid && op_code == asf_pkg::ASF_OP_ADD && !op_src_flags |=>
      flags_reg[3] == ($past(op_a[7]) == $past(op_b[7]) &&
      op_result[7] != $past(op_a[7]))) else $error("overflow wrong");
   chk_sub_borrow: assert property (@(posedge sys_clk) disable iff (sys_rst)
      op_valid && op_code == asf_pkg::ASF_OP_SUB && !op_src_flags |=>
      flags_reg[0] == ($past(op_a) >= $past(op_b)) &&
      flags_reg[1] == ($past(op_a[3:0]) >= $past(op_b[3:0])))
      else $error("borrow wrong");
   chk_rot_carry: assert property (@(posedge sys_clk) disable iff (sys_rst)
      op_valid && op_code == asf_pkg::ASF_OP_RLC && !op_src_flags |=>
      flags_reg[0] == $past(op_a[7]) && flags_reg[1] == $past(op_a[3]))
      else $error("rotate flags wrong");
   chk_hold_flags: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !op_valid && !reg_wr |=> flags_reg == $past(flags_reg))
      else $error("flags changed idle");
   chk_indexed_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !cfg_reg[0] |-> !indexed_mode_ok) else $error("indexed mode leaked");
   chk_dst_block: assert property (@(posedge sys_clk) disable iff (sys_rst)
      op_valid && op_dst_flags && !op_src_flags && op_code == asf_pkg::ASF_OP_ADD |=>
      flags_reg[4] == op_result[7] && flags_reg[2] == (op_result == 8'h00) &&
      flags_reg[1] == ($past(op_a[3:0]) > ~$past(op_b[3:0])) &&
      flags_reg[0] == ($past(op_a) > ~$past(op_b)))
      else $error("destination write leaked");
endmodule

// [design/asf_pkg.sv]
/*
 * Constants for the ALU status flag block: register offset, flag field
 * positions, reset value and the operation codes the core presents.
 * Assumes a single 50 MHz core clock and a byte-wide register port.
 */
package asf_pkg;
   // Register port address of the flag register
   localparam logic [7:0] ASF_FLAGS_ADDR = 8'h00;
   // Register port address of the configuration register
   localparam logic [7:0] ASF_CFG_ADDR = 8'h01;
   // Flag bit positions, then the extended set bit in the configuration register
   localparam int ASF_C_POS = 0;
   localparam int ASF_DC_POS = 1;
   localparam int ASF_Z_POS = 2;
   localparam int ASF_OV_POS = 3;
   localparam int ASF_N_POS = 4;
   localparam int ASF_XSET_POS = 0;
   // Mask of the five implemented flag bits
   localparam logic [7:0] ASF_IMPL_MASK = 8'h1F;
   // Reset value (flags are unknown at power-on; defined as zero here)
   localparam logic [4:0] ASF_FLAGS_RESET = 5'h00;
   localparam logic [7:0] ASF_CFG_RESET = 8'h00;
   // Operations the core can issue to the flag datapath
   typedef enum logic [3:0] {
      ASF_OP_NONE,
      ASF_OP_ADD,
      ASF_OP_SUB,
      ASF_OP_RRC,
      ASF_OP_RLC,
      ASF_OP_LOGIC,
      ASF_OP_CLR,
      ASF_OP_BCLR,
      ASF_OP_BSET,
      ASF_OP_SWAP,
      ASF_OP_MOVE
   } asf_op_t;
endpackage

// [design/asf_adder.sv]
/*
 * Eight-bit adder with nibble carry, carry and signed overflow outputs.
 * Assumes operands are already complemented by the caller for subtraction.
 */
module asf_adder (
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic cin,
   output logic [7:0] sum,
   output logic nib_carry,
   output logic carry,
   output logic ovf
);
   // Low nibble sum with its carry
   logic [4:0] low;
   // High nibble sum with its carry
   logic [4:0] high;

   // Two nibble adders chained
   always_comb begin
      low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      high = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, low[4]};
      sum = {high[3:0], low[3:0]};
      nib_carry = low[4];
      carry = high[4];
      // Same operand signs, different result sign
      ovf = (a[7] == b[7]) && (sum[7] != a[7]);
   end
endmodule

// [design/asf_rotator.sv]
/*
 * Rotate-through-carry helper: produces the rotated byte, the new carry
 * and the new nibble carry. Assumes the current carry is supplied.
 */
module asf_rotator (
   input wire logic [7:0] src,
   input wire logic cin,
   input wire logic left,
   output logic [7:0] res,
   output logic cout,
   output logic dcout
);
   // Select direction
   always_comb begin
      if (left) begin
         res = {src[6:0], cin};
         cout = src[7];
         dcout = src[3];
      end else begin
         res = {cin, src[7:1]};
         cout = src[0];
         dcout = src[4];
      end
   end
endmodule

// [verification/asf_status_flags_bench.sv]
/*
 * Self-checking bench for the ALU status flag block: reset values, a table of operations,
 * then register port, flag register as operand, mode enable and second reset cases.
 * Assumes the flag package and the flag block are compiled before it.
 */
module asf_status_flags_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // One table row: stimulus beside expected result and flags
   typedef struct {
      asf_pkg::asf_op_t op;
      logic [7:0] a;
      logic [7:0] b;
      logic [2:0] bn;
      logic [7:0] init;
      logic [7:0] res;
      logic [7:0] flg;
   } asf_row_t;
   localparam int MAX_CYC = 3000;
   localparam logic [7:0] FA = asf_pkg::ASF_FLAGS_ADDR;
   localparam logic [7:0] CA = asf_pkg::ASF_CFG_ADDR;
   // Ordinary cases: flags preset, operation, result, flags after
   asf_row_t rows [17] = '{
      '{asf_pkg::ASF_OP_ADD, 8'h7F, 8'h01, 3'h0, 8'h00, 8'h80, 8'h1A},
      '{asf_pkg::ASF_OP_ADD, 8'hFF, 8'h01, 3'h0, 8'h00, 8'h00, 8'h07},
      '{asf_pkg::ASF_OP_ADD, 8'h80, 8'h80, 3'h0, 8'h00, 8'h00, 8'h0D},
      '{asf_pkg::ASF_OP_SUB, 8'h05, 8'h03, 3'h0, 8'h00, 8'h02, 8'h03},
      '{asf_pkg::ASF_OP_SUB, 8'h03, 8'h05, 3'h0, 8'h1F, 8'hFE, 8'h10},
      '{asf_pkg::ASF_OP_SUB, 8'h80, 8'h01, 3'h0, 8'h00, 8'h7F, 8'h09},
      '{asf_pkg::ASF_OP_SUB, 8'h10, 8'h10, 3'h0, 8'h00, 8'h00, 8'h07},
      '{asf_pkg::ASF_OP_RRC, 8'h31, 8'h00, 3'h0, 8'h1C, 8'h18, 8'h1F},
      '{asf_pkg::ASF_OP_RRC, 8'hA4, 8'h00, 3'h0, 8'h03, 8'hD2, 8'h00},
      '{asf_pkg::ASF_OP_RLC, 8'h88, 8'h00, 3'h0, 8'h01, 8'h11, 8'h03},
      '{asf_pkg::ASF_OP_RLC, 8'h40, 8'h00, 3'h0, 8'h03, 8'h81, 8'h00},
      '{asf_pkg::ASF_OP_LOGIC, 8'h00, 8'h00, 3'h0, 8'h0B, 8'h00, 8'h0F},
      '{asf_pkg::ASF_OP_LOGIC, 8'h00, 8'h80, 3'h0, 8'h04, 8'h80, 8'h10},
      '{asf_pkg::ASF_OP_CLR, 8'h55, 8'h00, 3'h0, 8'h1B, 8'h00, 8'h1F},
      '{asf_pkg::ASF_OP_BCLR, 8'hFF, 8'h00, 3'h0, 8'h15, 8'hFE, 8'h15},
      '{asf_pkg::ASF_OP_BSET, 8'h00, 8'h00, 3'h7, 8'h0A, 8'h80, 8'h0A},
      '{asf_pkg::ASF_OP_SWAP, 8'h3C, 8'h00, 3'h0, 8'h10, 8'hC3, 8'h10}};
   logic sys_clk, sys_rst, reg_wr, reg_rd, op_valid, op_src_flags, op_dst_flags;
   logic indexed_mode_req, op_done, indexed_mode_ok;
   logic [7:0] reg_addr, reg_wdata, op_a, op_b, reg_rdata, op_result, f;
   logic [2:0] op_bit;
   asf_pkg::asf_op_t op_code;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   // Device under test, every input driven by the bench
   asf_status_flags dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .op_valid(op_valid), .op_code(op_code), .op_a(op_a), .op_b(op_b), .op_bit(op_bit),
      .op_src_flags(op_src_flags), .op_dst_flags(op_dst_flags), .op_result(op_result),
      .op_done(op_done), .indexed_mode_req(indexed_mode_req),
      .indexed_mode_ok(indexed_mode_ok));
   // 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // Byte compare
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t byte got %h expected %h", $time, got, exp);
      end
   endtask
   // Single bit compare
   task automatic chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t bit got %b expected %b", $time, got, exp);
      end
   endtask
   // Counts and verdict, then stop
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == MAX_CYC) begin
         fail_count++;
         $display("MISMATCH t=%0t timeout", $time);
         finish_test();
      end
   end
   // One-cycle register write
   task automatic reg_wr_t(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // One-cycle register read, data taken in the following cycle
   task automatic reg_rd_t(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask
   // One operation, completion pulse checked a cycle later
   task automatic do_op(input asf_pkg::asf_op_t c, input logic [7:0] a, input logic [7:0] b,
         input logic [2:0] bn, input logic src, input logic dst, input logic done);
      @(posedge sys_clk);
      op_valid <= 1'b1;
      op_code <= c;
      op_a <= a;
      op_b <= b;
      op_bit <= bn;
      op_src_flags <= src;
      op_dst_flags <= dst;
      @(posedge sys_clk);
      op_valid <= 1'b0;
      @(negedge sys_clk);
      chk1(op_done, done);
   endtask
   // Main sequence
   initial begin
      {sys_rst, reg_wr, reg_rd, op_valid, op_src_flags, op_dst_flags} = 6'h20;
      {reg_addr, reg_wdata, op_a, op_b, op_bit, indexed_mode_req} = '0;
      op_code = asf_pkg::ASF_OP_NONE;
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      // Reset values; read data stands one cycle only
      reg_rd_t(FA, f);
      chk8(f, 8'h00);
      reg_rd_t(CA, f);
      chk8(f, 8'h00);
      @(negedge sys_clk);
      chk8(reg_rdata, 8'h00);
      $display("test reset done");
      // Table of ordinary operations
      foreach (rows[i]) begin
         reg_wr_t(FA, rows[i].init);
         do_op(rows[i].op, rows[i].a, rows[i].b, rows[i].bn, 1'b0, 1'b0, 1'b1);
         chk8(op_result, rows[i].res);
         reg_rd_t(FA, f);
         chk8(f, rows[i].flg);
      end
      $display("test table done");
      // Upper bits, flag logic beating the written value
      reg_wr_t(FA, 8'hFF);
      reg_rd_t(FA, f);
      chk8(f, 8'h1F);
      reg_wr_t(FA, 8'h1B);
      do_op(asf_pkg::ASF_OP_CLR, 8'h00, 8'h00, 3'h0, 1'b0, 1'b1, 1'b1);
      reg_rd_t(FA, f);
      chk8(f, 8'h1F);
      reg_wr_t(FA, 8'h00);
      do_op(asf_pkg::ASF_OP_ADD, 8'h0F, 8'h0F, 3'h0, 1'b0, 1'b1, 1'b1);
      chk8(op_result, 8'h1E);
      reg_rd_t(FA, f);
      chk8(f, 8'h02);
      $display("test write block done");
      // Flag register as source of move, source and destination of bit set, destination of swap
      reg_wr_t(FA, 8'h15);
      do_op(asf_pkg::ASF_OP_MOVE, 8'h00, 8'h00, 3'h0, 1'b1, 1'b0, 1'b1);
      chk8(op_result, 8'h15);
      do_op(asf_pkg::ASF_OP_BSET, 8'h00, 8'h00, 3'h3, 1'b1, 1'b1, 1'b1);
      reg_rd_t(FA, f);
      chk8(f, 8'h1D);
      do_op(asf_pkg::ASF_OP_SWAP, 8'h5A, 8'h00, 3'h0, 1'b0, 1'b1, 1'b1);
      reg_rd_t(FA, f);
      chk8(f, 8'h05);
      do_op(asf_pkg::ASF_OP_NONE, 8'hFF, 8'hFF, 3'h0, 1'b0, 1'b1, 1'b0);
      reg_rd_t(FA, f);
      chk8(f, 8'h05);
      $display("test operand done");
      // Back to back: rotate uses the carry the add just made
      reg_wr_t(FA, 8'h00);
      @(posedge sys_clk);
      {op_valid, op_src_flags, op_dst_flags} <= 3'h4;
      op_code <= asf_pkg::ASF_OP_ADD;
      op_a <= 8'hFF;
      op_b <= 8'h01;
      @(posedge sys_clk);
      op_code <= asf_pkg::ASF_OP_RLC;
      op_a <= 8'h00;
      @(negedge sys_clk);
      chk8(op_result, 8'h00);
      @(posedge sys_clk);
      op_valid <= 1'b0;
      @(negedge sys_clk);
      chk8(op_result, 8'h01);
      chk1(op_done, 1'b1);
      $display("test back to back done");
      // Extended mode enable, config width, unmapped read
      @(posedge sys_clk);
      indexed_mode_req <= 1'b1;
      @(negedge sys_clk);
      chk1(indexed_mode_ok, 1'b0);
      reg_wr_t(CA, 8'hFF);
      reg_rd_t(CA, f);
      chk8(f, 8'h01);
      chk1(indexed_mode_ok, 1'b1);
      reg_rd_t(8'h7E, f);
      chk8(f, 8'h00);
      $display("test mode enable done");
      // Second reset in mid-run
      reg_wr_t(FA, 8'h1F);
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      @(posedge sys_clk);
      sys_rst <= 1'b0;
      reg_rd_t(FA, f);
      chk8(f, 8'h00);
      chk1(indexed_mode_ok, 1'b0);
      $display("test second reset done");
      finish_test();
   end
endmodule
